// >>> upd_pkg.sv
package upd_pkg;
  // frame format
  localparam int unsigned UPD_DIV_W      = 16;
  localparam int unsigned UPD_OVS        = 16;  // samples per bit
  localparam int unsigned UPD_OVS_MID    = 7;   // sample point inside a bit
  localparam int unsigned UPD_FIFO_DEPTH = 8;
  localparam logic [1:0]  UPD_LEN5       = 2'h0;
  localparam logic [3:0]  UPD_BASE_BITS  = 4'h5;
  localparam logic [3:0]  UPD_OVS_LAST   = 4'hf;
  localparam logic [3:0]  UPD_MID_CNT    = 4'h7;

  // parity selection
  typedef enum logic [1:0] {
    UPD_PAR_NONE = 2'h0,
    UPD_PAR_EVEN = 2'h1,
    UPD_PAR_ODD  = 2'h2
  } upd_par_t;

  // line format settings
  typedef struct packed {
    logic [1:0]           len;      // data bits minus five
    logic                 stop2;    // two stop bits
    upd_par_t             par;
    logic                 addr_en;  // ninth address bit mode
    logic [UPD_DIV_W-1:0] divisor;  // zero means 65536
  } upd_cfg_t;

  // character with its ninth bit
  typedef struct packed {
    logic       addr;
    logic [7:0] data;
  } upd_char_t;

  // receive status
  typedef struct packed {
    logic par_err;
    logic frm_err;
    logic ovr_err;
  } upd_err_t;

  // one-hot frame states
  typedef enum logic [5:0] {
    UPD_IDLE  = 6'h01,
    UPD_START = 6'h02,
    UPD_DATA  = 6'h04,
    UPD_PAR   = 6'h08,
    UPD_ADDR  = 6'h10,
    UPD_STOP  = 6'h20
  } upd_state_t;
endpackage

// >>> upd_fifo.sv
module upd_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // write side
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  input  wire logic [WIDTH-1:0] i_wdata,
  // read side
  output logic                  o_rvalid,
  input  wire logic             i_rready,
  output logic      [WIDTH-1:0] o_rdata
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             wr;
  logic             rd;

  // handshakes
  assign o_wready = (cnt_q != (AW+1)'(DEPTH));
  assign o_rvalid = (cnt_q != '0);
  assign o_rdata  = mem_q[rp_q];
  assign wr       = i_wvalid && o_wready;
  assign rd       = o_rvalid && i_rready;

  // storage
  always_ff @(posedge i_clock) begin
    if (wr) begin
      mem_q[wp_q] <= i_wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// >>> upd_uart.sv
// What this block does
// - transmitter and receiver run independently at the same time
// - optional ninth bit marks address characters; receiver can filter for addresses
// - five to eight data bits per character
// - one or two stop bits sent; receiver checks configured stop bits
// - parity none, even or odd; generated on transmit, checked on receive
// - programmed transfers write and read holding registers through ports
// - transmit and receive each buffered while shifting
// - separate transmit and receive dma request lines in dma mode
// - dma requests flagged low priority for the arbiter
// - bit rate from clock over 1048576 up to clock over 16
// - frames of seven to thirteen bit times
// - transmit and receive interrupts each with own mask
// - receive errors reported, each error flag enabled by software
// - raw receive line exposed for an external timer to measure bits
module upd_uart
  import upd_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // configuration
  input  wire upd_cfg_t   i_cfg,
  input  wire logic       i_dma_mode,
  input  wire logic       i_addr_filter,
  input  wire upd_err_t   i_err_en,
  input  wire logic       i_tx_irq_en,
  input  wire logic       i_rx_irq_en,
  // transmit holding register
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire upd_char_t  i_tx_char,
  // receive holding register
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output upd_char_t       o_rx_char,
  // status
  output upd_err_t        o_err,
  input  wire logic       i_err_clr,
  output logic            o_tx_busy,
  // requests
  output logic            o_tx_irq,
  output logic            o_rx_irq,
  output logic            o_tx_dma_req,
  output logic            o_rx_dma_req,
  output logic            o_dma_low_prio,
  // serial line
  output logic            o_txd,
  input  wire logic       i_rxd,
  output logic            o_rxd_timer
);
  // rate divider and frame length
  logic [UPD_DIV_W-1:0] div_q;
  logic                 tick;
  logic [3:0]           nbits;
  // transmit queue read side
  logic                 q_valid;
  logic                 q_ready;
  upd_char_t            q_char;
  // transmit
  upd_state_t           ts_q;
  logic [3:0]           tov_q;
  logic [2:0]           tbit_q;
  logic [7:0]           tsh_q;
  logic                 taddr_q;
  logic                 tpar_q;
  logic                 tstop_q;
  logic                 txd_q;
  // receive
  upd_state_t           rs_q;
  logic [3:0]           rov_q;
  logic [2:0]           rbit_q;
  logic [7:0]           rsh_q;
  logic                 raddr_q;
  logic                 rpar_q;
  logic                 rstop_q;
  logic                 rperr_q;
  // receive completion and status
  logic                 done;
  logic                 keep;
  logic                 f_wready;
  upd_err_t             err_q;
  logic                 t_bit_end;
  logic                 r_sample;

  // rate pulse sixteen times per bit
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (tick) begin
      // reload one below the divisor so each period spans divisor clocks
      div_q <= i_cfg.divisor - 1'b1;
    end else begin
      div_q <= div_q - 1'b1;
    end
  end
  assign tick  = (div_q == '0);
  assign nbits = UPD_BASE_BITS + {2'h0, i_cfg.len};

  // transmit fifo queues characters while one shifts
  // processor writes through the valid/ready port
  upd_fifo #(.WIDTH($bits(upd_char_t)), .DEPTH(UPD_FIFO_DEPTH)) u_txq (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_wvalid (i_tx_valid),
    .o_wready (o_tx_ready),
    .i_wdata  (i_tx_char),
    .o_rvalid (q_valid),
    .i_rready (q_ready),
    .o_rdata  (q_char)
  );
  assign q_ready   = (ts_q == UPD_IDLE) && tick;
  assign t_bit_end = tick && (tov_q == UPD_OVS_LAST);

  // transmit state machine, independent of receive
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ts_q    <= UPD_IDLE;
      tov_q   <= '0;
      tbit_q  <= '0;
      tsh_q   <= '0;
      taddr_q <= 1'b0;
      tpar_q  <= 1'b0;
      tstop_q <= 1'b0;
    end else begin
      if (tick) begin
        tov_q <= tov_q + 1'b1;
      end
      unique case (ts_q)
        UPD_IDLE: begin
          // characters taken only on a rate pulse, so the start bit is aligned
          if (q_valid && tick) begin
            ts_q    <= UPD_START;
            tov_q   <= '0;
            tsh_q   <= q_char.data;
            taddr_q <= q_char.addr;
            // parity seed: odd starts at one
            tpar_q  <= (i_cfg.par == UPD_PAR_ODD);
          end
        end
        UPD_START: begin
          if (t_bit_end) begin
            ts_q   <= UPD_DATA;
            tbit_q <= '0;
          end
        end
        UPD_DATA: begin
          if (t_bit_end) begin
            // shift out least significant bit first
            tsh_q  <= {1'b0, tsh_q[7:1]};
            tpar_q <= tpar_q ^ tsh_q[0];
            tbit_q <= tbit_q + 1'b1;
            // parity and address bits lengthen the frame
            if ({1'b0, tbit_q} == nbits - 1'b1) begin
              if (i_cfg.par != UPD_PAR_NONE) begin
                ts_q <= UPD_PAR;
              end else if (i_cfg.addr_en) begin
                ts_q <= UPD_ADDR;
              end else begin
                ts_q <= UPD_STOP;
              end
              tstop_q <= 1'b0;
            end
          end
        end
        UPD_PAR: begin
          if (t_bit_end) begin
            ts_q <= i_cfg.addr_en ? UPD_ADDR : UPD_STOP;
          end
        end
        UPD_ADDR: begin
          if (t_bit_end) begin
            ts_q <= UPD_STOP;
          end
        end
        UPD_STOP: begin
          if (t_bit_end) begin
            if (i_cfg.stop2 && !tstop_q) begin
              tstop_q <= 1'b1;
            end else begin
              ts_q <= UPD_IDLE;
            end
          end
        end
        default: ts_q <= UPD_IDLE;
      endcase
    end
  end

  // line driver, registered
  // idle high, start low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txd_q <= 1'b1;
    end else begin
      unique case (ts_q)
        UPD_START: txd_q <= 1'b0;
        UPD_DATA:  txd_q <= tsh_q[0];
        UPD_PAR:   txd_q <= tpar_q;
        // ninth bit set on address characters
        UPD_ADDR:  txd_q <= taddr_q;
        default:   txd_q <= 1'b1;
      endcase
    end
  end
  assign o_txd       = txd_q;
  assign o_tx_busy   = (ts_q != UPD_IDLE) || q_valid;
  // receive line handed to the rate timer
  assign o_rxd_timer = i_rxd;
  assign r_sample    = tick && (rov_q == UPD_MID_CNT);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs_q    <= UPD_IDLE;
      rov_q   <= '0;
      rbit_q  <= '0;
      rsh_q   <= '0;
      raddr_q <= 1'b0;
      rpar_q  <= 1'b0;
      rstop_q <= 1'b0;
      rperr_q <= 1'b0;
    end else begin
      if (tick) begin
        rov_q <= rov_q + 1'b1;
      end
      unique case (rs_q)
        UPD_IDLE: begin
          // line taken as synchronous, no extra flops in front
          // low line seen on a rate pulse opens a frame
          if (tick && !i_rxd) begin
            rs_q    <= UPD_START;
            rov_q   <= '0;
            rsh_q   <= '0;
            raddr_q <= 1'b0;
            rperr_q <= 1'b0;
            rstop_q <= 1'b0;
            rpar_q  <= (i_cfg.par == UPD_PAR_ODD);
          end
        end
        UPD_START: begin
          // counter restarts at mid start bit, later samples fall mid bit
          if (r_sample) begin
            // false start rejected
            rs_q   <= i_rxd ? UPD_IDLE : UPD_DATA;
            rbit_q <= '0;
            rov_q  <= '0;
          end
        end
        UPD_DATA: begin
          if (tick && rov_q == UPD_OVS_LAST) begin
            rsh_q[rbit_q] <= i_rxd;
            rpar_q <= rpar_q ^ i_rxd;
            rbit_q <= rbit_q + 1'b1;
            if ({1'b0, rbit_q} == nbits - 1'b1) begin
              if (i_cfg.par != UPD_PAR_NONE) begin
                rs_q <= UPD_PAR;
              end else if (i_cfg.addr_en) begin
                rs_q <= UPD_ADDR;
              end else begin
                rs_q <= UPD_STOP;
              end
            end
          end
        end
        UPD_PAR: begin
          if (tick && rov_q == UPD_OVS_LAST) begin
            rperr_q <= rpar_q ^ i_rxd;
            rs_q    <= i_cfg.addr_en ? UPD_ADDR : UPD_STOP;
          end
        end
        UPD_ADDR: begin
          if (tick && rov_q == UPD_OVS_LAST) begin
            raddr_q <= i_rxd;
            rs_q    <= UPD_STOP;
          end
        end
        UPD_STOP: begin
          if (tick && rov_q == UPD_OVS_LAST) begin
            if (i_cfg.stop2 && !rstop_q && i_rxd) begin
              rstop_q <= 1'b1;
            end else begin
              rs_q <= UPD_IDLE;
            end
          end
        end
        default: rs_q <= UPD_IDLE;
      endcase
    end
  end

  // a low stop bit still ends the frame and counts as a framing error
  // frame complete at stop sample
  assign done = (rs_q == UPD_STOP) && tick && (rov_q == UPD_OVS_LAST)
                && !(i_cfg.stop2 && !rstop_q && i_rxd);
  assign keep = !(i_cfg.addr_en && i_addr_filter && !raddr_q);

  // receive fifo holds characters while the next arrives
  upd_fifo #(.WIDTH($bits(upd_char_t)), .DEPTH(UPD_FIFO_DEPTH)) u_rxq (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_wvalid (done && keep),
    .o_wready (f_wready),
    .i_wdata  ({raddr_q, rsh_q}),
    .o_rvalid (o_rx_valid),
    .i_rready (i_rx_ready),
    .o_rdata  (o_rx_char)
  );

  // a character meeting a full fifo is lost; only the overrun flag shows it
  // sticky error flags, set wins over clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q <= '0;
    end else begin
      err_q.par_err <= (err_q.par_err && !i_err_clr)
                       || (done && rperr_q && i_err_en.par_err);
      err_q.frm_err <= (err_q.frm_err && !i_err_clr)
                       || (done && !i_rxd && i_err_en.frm_err);
      err_q.ovr_err <= (err_q.ovr_err && !i_err_clr)
                       || (done && keep && !f_wready && i_err_en.ovr_err);
    end
  end
  assign o_err = err_q;

  // in dma mode the request lines take over the data interrupts
  // masked transmit and receive interrupts
  assign o_tx_irq       = i_tx_irq_en && !i_dma_mode && o_tx_ready;
  assign o_rx_irq       = i_rx_irq_en && ((!i_dma_mode && o_rx_valid) || (err_q != '0));
  assign o_tx_dma_req   = i_dma_mode && o_tx_ready;
  assign o_rx_dma_req   = i_dma_mode && o_rx_valid;
  // low priority hint to the arbiter
  assign o_dma_low_prio = 1'b1;
endmodule

// >>> upd_uart_asserts.sv
module upd_uart_chk
  import upd_pkg::*;
(
  // clock and reset
  input wire logic      i_clock,
  input wire logic      i_rst_n,
  // inputs watched
  input wire upd_err_t  i_err_en,
  input wire logic      i_dma_mode,
  input wire logic      i_err_clr,
  input wire logic      i_tx_irq_en,
  input wire logic      i_rx_irq_en,
  input wire logic      i_rx_ready,
  input wire logic      i_rxd,
  // outputs watched
  input wire logic      o_tx_ready,
  input wire logic      o_rx_valid,
  input wire upd_char_t o_rx_char,
  input wire upd_err_t  o_err,
  input wire logic      o_tx_busy,
  input wire logic      o_tx_irq,
  input wire logic      o_rx_irq,
  input wire logic      o_tx_dma_req,
  input wire logic      o_rx_dma_req,
  input wire logic      o_dma_low_prio,
  input wire logic      o_txd,
  input wire logic      o_rxd_timer
);
  // one clock domain for every check
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  chk_low_prio: assert property (o_dma_low_prio)
    else $error("dma priority flag not set");
  chk_tx_irq: assert property (o_tx_irq == (i_tx_irq_en & !i_dma_mode & o_tx_ready))
    else $error("tx irq wrong");
  chk_tx_dma: assert property (o_tx_dma_req == (i_dma_mode & o_tx_ready))
    else $error("tx dma request wrong");
  chk_rx_dma: assert property (o_rx_dma_req == (i_dma_mode & o_rx_valid))
    else $error("rx dma request wrong");
  chk_rx_irq: assert property (o_rx_irq == (i_rx_irq_en & ((!i_dma_mode & o_rx_valid) | (|o_err))))
    else $error("rx irq wrong");
  chk_timer_line: assert property (o_rxd_timer == i_rxd)
    else $error("timer line differs from rx line");
  chk_idle_high: assert property (!o_tx_busy && !$past(o_tx_busy) |-> o_txd)
    else $error("line not high while idle");
  chk_start_hold: assert property ($fell(o_txd) |-> (!o_txd) [*8])
    else $error("start bit too short");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_char))
    else $error("held char changed");
  chk_err_hold: assert property (o_err != 3'h0 && !i_err_clr |=> (o_err & $past(o_err)) == $past(o_err))
    else $error("error flag lost");
  chk_err_gate: assert property ($rose(o_err.par_err) |-> $past(i_err_en.par_err))
    else $error("parity flag set while disabled");
endmodule

bind upd_uart upd_uart_chk u_upd_uart_chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_err_en(i_err_en), .i_dma_mode(i_dma_mode),
  .i_err_clr(i_err_clr), .i_tx_irq_en(i_tx_irq_en), .i_rx_irq_en(i_rx_irq_en),
  .i_rx_ready(i_rx_ready), .i_rxd(i_rxd), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
  .o_rx_char(o_rx_char), .o_err(o_err), .o_tx_busy(o_tx_busy), .o_tx_irq(o_tx_irq),
  .o_rx_irq(o_rx_irq), .o_tx_dma_req(o_tx_dma_req), .o_rx_dma_req(o_rx_dma_req),
  .o_dma_low_prio(o_dma_low_prio), .o_txd(o_txd), .o_rxd_timer(o_rxd_timer)
);

// >>> upd_remote.sv
module upd_remote (
  // clock
  input  wire logic i_clock,
  // serial lines
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_clks = 16; // clocks per bit, set by the bench

  // line rests high
  initial o_line = 1'b1;

  task automatic send(input logic [12:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      o_line = f[k];
      repeat (bit_clks) @(posedge i_clock);
      #1;
    end
    // the closing stop bit already leaves the line high
  endtask

  task automatic get(input int n, output logic [12:0] f);
    f = '1;
    @(posedge i_clock);
    while (i_line !== 1'b0) @(posedge i_clock);
    repeat (bit_clks / 2) @(posedge i_clock);
    for (int k = 0; k < n; k++) begin
      f[k] = i_line;
      if (k < n - 1) repeat (bit_clks) @(posedge i_clock);
    end
  endtask
endmodule

// >>> upd_tb.sv
module testbench
  import upd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clock, i_rst_n, i_dma_mode, i_addr_filter, i_err_clr, i_rx_irq_en;
  logic        i_tx_valid, i_rx_ready, o_tx_ready, o_rx_valid, o_tx_irq, o_rx_irq;
  logic        o_tx_dma_req, o_dma_low_prio, o_txd, i_tx_irq_en;
  wire logic   rxd;
  upd_cfg_t    i_cfg;
  upd_err_t    i_err_en, o_err;
  upd_char_t   i_tx_char, o_rx_char, c;
  upd_char_t   wbuf [10];
  upd_cfg_t    cfgs [5];
  logic [12:0] ef, rf, g;
  int          n, held;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  upd_uart u_upd_uart (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg(i_cfg), .i_dma_mode(i_dma_mode),
    .i_addr_filter(i_addr_filter), .i_err_en(i_err_en), .i_tx_irq_en(i_tx_irq_en),
    .i_rx_irq_en(i_rx_irq_en), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .i_tx_char(i_tx_char), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_rx_char(o_rx_char), .o_err(o_err), .i_err_clr(i_err_clr), .o_tx_busy(),
    .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_tx_dma_req(o_tx_dma_req),
    .o_rx_dma_req(), .o_dma_low_prio(o_dma_low_prio), .o_txd(o_txd), .i_rxd(rxd),
    .o_rxd_timer()
  );
  upd_remote u_upd_remote (.i_clock(i_clock), .i_line(o_txd), .o_line(rxd));

  task tick;
    @(posedge i_clock);
    #1;
  endtask
  task end_of_test;
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task note(input logic ok, input string m);
    samples_checked++;
    if (!ok) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task cmp_vec(input logic [12:0] gv, ev, input string m);
    note(gv === ev, m);
  endtask
  task cmp_char(input upd_char_t gc, ec);
    note(gc === ec, "received char");
  endtask
  task cmp_bit(input logic gb, eb, input string m);
    note(gb === eb, m);
  endtask

  // expected line bits, first bit at index 0
  function automatic logic [12:0] frame(upd_cfg_t cf, upd_char_t ch, output int nb);
    logic [12:0] f;
    logic        p;
    f = '1;
    p = 1'b0;
    f[0] = 1'b0;
    nb = 1;
    for (int k = 0; k < cf.len + 5; k++) begin
      f[nb] = ch.data[k];
      p = p ^ ch.data[k];
      nb++;
    end
    if (cf.par != UPD_PAR_NONE) begin
      f[nb] = p ^ (cf.par == UPD_PAR_ODD);
      nb++;
    end
    if (cf.addr_en) begin
      f[nb] = ch.addr;
      nb++;
    end
    nb = nb + 1 + cf.stop2;
    return f;
  endfunction
  function automatic upd_char_t msk(upd_cfg_t cf, upd_char_t ch);
    return ch & {cf.addr_en, 8'(8'hff >> (3 - cf.len))};
  endfunction

  task wr(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      i_tx_char = wbuf[k];
      i_tx_valid = 1'b1;
      while (o_tx_ready !== 1'b1) begin
        held++;
        tick;
      end
      tick;
    end
    i_tx_valid = 1'b0;
  endtask
  task rd(output upd_char_t rc);
    while (o_rx_valid !== 1'b1) tick;
    rc = o_rx_char;
    i_rx_ready = 1'b1;
    tick;
    i_rx_ready = 1'b0;
    tick;
  endtask
  // one char each way at the same time
  task xfer(input upd_char_t tc, input upd_char_t rc);
    wbuf[0] = tc;
    ef = frame(i_cfg, tc, n);
    rf = frame(i_cfg, rc, n);
    fork
      wr(1);
      begin
        u_upd_remote.get(n, g);
        cmp_vec(g, ef, "tx frame");
      end
      begin
        u_upd_remote.send(rf, n);
        rd(c);
        cmp_char(msk(i_cfg, c), msk(i_cfg, rc));
      end
    join
  endtask
  task errf(input logic [12:0] flip, input upd_err_t e);
    rf = frame(i_cfg, 9'h0a5, n) ^ flip;
    u_upd_remote.send(rf, n);
    repeat (2) tick;
    cmp_vec(13'(o_err), 13'(e), "error flags");
    i_err_clr = 1'b1;
    tick;
    i_err_clr = 1'b0;
    while (o_rx_valid === 1'b1) rd(c);
  endtask

  // hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      note(1'b0, "run timed out");
      end_of_test;
    end
  end

  initial begin
    i_rst_n = 1'b0;
    i_cfg = '0;
    i_dma_mode = 1'b0;
    i_addr_filter = 1'b0;
    i_err_en = '1;
    i_err_clr = 1'b0;
    i_rx_irq_en = 1'b1;
    i_tx_irq_en = 1'b1;
    i_tx_valid = 1'b0;
    i_tx_char = '0;
    i_rx_ready = 1'b0;
    cfgs[0] = '{2'h0, 1'b0, UPD_PAR_NONE, 1'b0, 16'h0001};
    cfgs[1] = '{2'h3, 1'b1, UPD_PAR_EVEN, 1'b0, 16'h0001};
    cfgs[2] = '{2'h1, 1'b0, UPD_PAR_ODD, 1'b1, 16'h0002};
    cfgs[3] = '{2'h2, 1'b1, UPD_PAR_ODD, 1'b0, 16'h0001};
    cfgs[4] = '{2'h3, 1'b0, UPD_PAR_EVEN, 1'b1, 16'h0001};
    i_cfg = cfgs[0];
    repeat (20) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    cmp_bit(o_txd, 1'b1, "line idle");
    cmp_bit(o_tx_ready, 1'b1, "tx ready after reset");
    cmp_bit(o_rx_valid, 1'b0, "rx empty after reset");
    cmp_bit(o_dma_low_prio, 1'b1, "dma priority");
    // five formats, both directions at once
    for (int k = 0; k < 5; k++) begin
      i_cfg = cfgs[k];
      u_upd_remote.bit_clks = 16 * i_cfg.divisor;
      tick;
      xfer({1'b1, 8'(8'h35 + k)}, {k[0], 8'(8'hca - k)});
    end
    // receive errors and the parity error enable
    i_cfg = cfgs[1];
    u_upd_remote.bit_clks = 16;
    i_err_en = 3'h3;
    errf(13'h0200, 3'h0);
    i_err_en = 3'h7;
    errf(13'h0200, 3'h4);
    errf(13'h0400, 3'h2);
    // address filter keeps only address chars
    i_cfg = cfgs[4];
    i_addr_filter = 1'b1;
    rf = frame(i_cfg, 9'h011, n);
    u_upd_remote.send(rf, n);
    rf = frame(i_cfg, 9'h177, n);
    u_upd_remote.send(rf, n);
    rd(c);
    cmp_char(c, 9'h177);
    i_addr_filter = 1'b0;
    // receive buffer filled past its depth
    i_cfg = cfgs[1];
    i_rx_irq_en = 1'b0;
    for (int k = 0; k < 9; k++) begin
      rf = frame(i_cfg, 9'(8'h40 + k), n);
      u_upd_remote.send(rf, n);
    end
    repeat (2) tick;
    cmp_bit(o_err.ovr_err, 1'b1, "overrun flag");
    cmp_bit(o_rx_irq, 1'b0, "rx irq masked");
    for (int k = 0; k < 8; k++) begin
      rd(c);
      cmp_char(msk(i_cfg, c), 9'(8'h40 + k));
    end
    i_err_clr = 1'b1;
    i_rx_irq_en = 1'b1;
    tick;
    i_err_clr = 1'b0;
    // transmit interrupt and its mask
    cmp_bit(o_tx_irq, 1'b1, "tx irq when room");
    i_tx_irq_en = 1'b0;
    tick;
    cmp_bit(o_tx_irq, 1'b0, "tx irq masked");
    i_tx_irq_en = 1'b1;
    // transmit buffer filled in dma mode
    i_cfg = cfgs[0];
    i_dma_mode = 1'b1;
    held = 0;
    for (int k = 0; k < 10; k++) wbuf[k] = 9'(8'h20 + k);
    fork
      wr(10);
      for (int k = 0; k < 10; k++) begin
        ef = frame(i_cfg, wbuf[k], n);
        u_upd_remote.get(n, g);
        cmp_vec(g, ef, "queued tx frame");
      end
    join
    cmp_bit(held != 0, 1'b1, "full tx buffer refused");
    cmp_bit(o_tx_dma_req, 1'b1, "tx dma request");
    cmp_bit(o_tx_irq, 1'b0, "tx irq in dma mode");
    end_of_test;
  end
endmodule
